//--- hw/crcc_pkg.sv
// Constants and types of the CRC calculator
package crcc_pkg;
    localparam int CRCC_ADDR_W = 4;
    localparam logic [CRCC_ADDR_W-1:0] CRCC_OFS_DATA = 4'h0;
    localparam logic [CRCC_ADDR_W-1:0] CRCC_OFS_SCRATCH = 4'h4;
    localparam logic [CRCC_ADDR_W-1:0] CRCC_OFS_CTRL = 4'h8;
    localparam logic [31:0] CRCC_POLY = 32'h04c11db7;
    localparam logic [31:0] CRCC_SEED = 32'hffffffff;
    localparam logic [7:0] CRCC_SCRATCH_RST = 8'h00;
    localparam int CRCC_RESEED_BIT = 0;
    localparam int CRCC_FIFO_DEPTH = 8;
    localparam logic [1:0] CRCC_CALC_LAST = 2'h3;
    localparam logic [1:0] CRCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CRCC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CRCC_IDLE = 2'b01,
        CRCC_CALC = 2'b10
    } crcc_state_t;

    // One byte into the running CRC, most significant bit first
    function automatic logic [31:0] crccByte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[31] ^ d[i]) begin
                r = {r[30:0], 1'b0} ^ CRCC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction

    // One whole word, high byte first
    function automatic logic [31:0] crccWord(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = crccByte(c, d[31:24]);
        r = crccByte(r, d[23:16]);
        r = crccByte(r, d[15:8]);
        r = crccByte(r, d[7:0]);
        return r;
    endfunction
endpackage

//--- hw/crcc_top.sv
// CRC-32 calculator with AXI4-Lite registers and input word FIFO
// Notes on behaviour
// - CRC-32 with polynomial 0x04c11db7 over every whole word written to offset 0x00
// - Each word takes exactly four clock cycles in the engine
// - New result folds the new word into the previous result
// - Control writes stall while a calculation would be overtaken
// - Write to offset 0x00 with all four strobes feeds a new word to the engine
// - Read of offset 0x00 returns the CRC; all ones after reset
// - Offset 0x04 holds a read/write scratch byte, reset zero
// - Re-seeding leaves the scratch byte unchanged
// - Scratch byte never affects the CRC
// - Bit 0 at offset 0x08 re-seeds CRC to ones, self-clearing
// - Upper scratch bits and control bits 31:1 are reserved
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module crcc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] scratch_byte_field,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    wire logic push = inValid && inReady;
    wire logic pop = outValid && outReady;

    assign inReady = count_q != CW'(DEPTH);
    assign outValid = count_q != '0;
    assign outData = mem[rdPtr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= scratch_byte_field;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule

module crcc_top #(
    parameter int FIFO_DEPTH = crcc_pkg::CRCC_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [crcc_pkg::CRCC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [crcc_pkg::CRCC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import crcc_pkg::*;

    logic awHeld_q;
    logic wHeld_q;
    logic arHeld_q;
    logic [CRCC_ADDR_W-1:0] awAddr_q;
    logic [CRCC_ADDR_W-1:0] arAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awready_q;
    logic wready_q;
    logic arready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] crc_q;
    logic [31:0] word_q;
    logic [1:0] cnt_q;
    logic [7:0] scratch_q;
    logic reseed_q;
    crcc_state_t state_q;
    logic fifoInReady;
    logic fifoOutValid;
    logic [31:0] fifoOutData;

    // Write side decode
    wire logic awTake = s_axi_awvalid && awready_q;
    wire logic wTake = s_axi_wvalid && wready_q;
    wire logic wrIsData = awAddr_q == CRCC_OFS_DATA;
    wire logic wrIsScratch = awAddr_q == CRCC_OFS_SCRATCH;
    wire logic wrIsCtrl = awAddr_q == CRCC_OFS_CTRL;
    wire logic wrFull = wStrb_q == 4'hf;
    wire logic engineIdle = state_q == CRCC_IDLE && !fifoOutValid && !reseed_q;
    wire logic wrReady = wrIsData ? fifoInReady : (wrIsCtrl ? engineIdle : 1'b1);
    wire logic doWrite = awHeld_q && wHeld_q && !bvalid_q && wrReady;
    wire logic fifoInValid = doWrite && wrIsData && wrFull;
    wire logic reseedReq = doWrite && wrIsCtrl && wStrb_q[0] && wData_q[CRCC_RESEED_BIT];
    wire logic wrBad = !(wrIsData || wrIsScratch || wrIsCtrl) || (wrIsData && !wrFull);
    wire logic awHeld_d = doWrite ? 1'b0 : (awHeld_q || awTake);
    wire logic wHeld_d = doWrite ? 1'b0 : (wHeld_q || wTake);

    // Read side decode
    wire logic arTake = s_axi_arvalid && arready_q;
    wire logic rdIsData = arAddr_q == CRCC_OFS_DATA;
    wire logic rdIsScratch = arAddr_q == CRCC_OFS_SCRATCH;
    wire logic rdIsCtrl = arAddr_q == CRCC_OFS_CTRL;
    wire logic doRead = arHeld_q && !rvalid_q && (!rdIsData || engineIdle);
    wire logic [31:0] rdMux = rdIsData ? crc_q :
        (rdIsScratch ? {24'h000000, scratch_q} : 32'h00000000);
    wire logic rdBad = !(rdIsData || rdIsScratch || rdIsCtrl);
    wire logic arHeld_d = doRead ? 1'b0 : (arHeld_q || arTake);

    // Engine control
    wire logic fifoPop = fifoOutValid && state_q == CRCC_IDLE && !reseed_q;
    wire logic inCalc = state_q == CRCC_CALC;
    wire logic calcLast = inCalc && cnt_q == CRCC_CALC_LAST;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    crcc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) inFifo (
        .clk(clk),
        .rst(rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .scratch_byte_field(wData_q),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOutData)
    );

    // Write address and data capture
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awready_q <= !awHeld_d;
            wready_q <= !wHeld_d;
            if (awTake) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= CRCC_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
            bresp_q <= wrBad ? CRCC_RESP_SLVERR : CRCC_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk) begin
        if (rst) begin
            arHeld_q <= 1'b0;
            arready_q <= 1'b0;
            arAddr_q <= '0;
            rvalid_q <= 1'b0;
            rresp_q <= CRCC_RESP_OKAY;
            rdata_q <= '0;
        end else begin
            arHeld_q <= arHeld_d;
            arready_q <= !arHeld_d;
            if (arTake) begin
                arAddr_q <= s_axi_araddr;
            end
            if (doRead) begin
                rvalid_q <= 1'b1;
                rdata_q <= rdMux;
                rresp_q <= rdBad ? CRCC_RESP_SLVERR : CRCC_RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Scratch byte, untouched by the engine and re-seed
    always_ff @(posedge clk) begin
        if (rst) begin
            scratch_q <= CRCC_SCRATCH_RST;
        end else if (doWrite && wrIsScratch && wStrb_q[0]) begin
            scratch_q <= wData_q[7:0];
        end
    end

    // Self-clearing re-seed request
    always_ff @(posedge clk) begin
        if (rst) begin
            reseed_q <= 1'b0;
        end else begin
            reseed_q <= reseedReq;
        end
    end

    // CRC engine, one byte per cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= CRCC_IDLE;
            cnt_q <= '0;
            word_q <= '0;
            crc_q <= CRCC_SEED;
        end else begin
            unique case (state_q)
                CRCC_IDLE: begin
                    if (reseed_q) begin
                        crc_q <= CRCC_SEED;
                    end else if (fifoPop) begin
                        word_q <= fifoOutData;
                        cnt_q <= '0;
                        state_q <= CRCC_CALC;
                    end
                end
                CRCC_CALC: begin
                    crc_q <= crccByte(crc_q, word_q[31:24]);
                    word_q <= {word_q[23:0], 8'h00};
                    cnt_q <= cnt_q + 2'h1;
                    if (calcLast) begin
                        state_q <= CRCC_IDLE;
                    end
                end
                default: begin
                    state_q <= CRCC_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_calc_four_cyc: assert property (fifoPop |=> inCalc [*4] ##1 !inCalc)
        else $error("engine did not take four cycles");
    a_crc_word_fold: assert property (fifoPop |-> ##5
        crc_q == crccWord($past(crc_q, 5), $past(fifoOutData, 5)))
        else $error("crc result wrong after word");
    a_ctrl_wr_stall: assert property (doWrite && wrIsCtrl |-> !inCalc && !fifoOutValid)
        else $error("control write during calculation");
    a_data_rd_stall: assert property (doRead && rdIsData |-> !inCalc && !fifoOutValid)
        else $error("data read before calculation done");
    a_data_push_word: assert property (doWrite && wrIsData && wrFull |=> fifoOutValid)
        else $error("data word lost");
    a_seed_after_rst: assert property ($fell(rst) |-> crc_q == CRCC_SEED)
        else $error("crc not all ones after reset");
    a_reseed_ones: assert property (reseedReq |=> reseed_q ##1 !reseed_q && crc_q == CRCC_SEED)
        else $error("re-seed failed");
    a_scratch_keep: assert property ((reseed_q || inCalc) && !(doWrite && wrIsScratch)
        |=> $stable(scratch_q))
        else $error("scratch changed by engine");
    a_rsvd_read_zero: assert property (doRead && !rdIsData |=> rdata_q[31:8] == 24'h000000)
        else $error("reserved bits not zero");

    c_word_done: cover property (fifoPop ##5 s_axi_arvalid);
    c_fifo_full: cover property (!fifoInReady ##1 fifoPop);
    c_reseed: cover property (reseedReq ##2 doRead && rdIsData);
endmodule

`default_nettype wire

//--- dv/crcc_top_tb.sv
// Register-level testbench of the CRC calculator
`timescale 1ns/1ps
`default_nettype none

module crcc_top_tb;
    import crcc_pkg::*;

    logic clk;
    logic rst;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int checked;
    int failures;

    crcc_top #(.FIFO_DEPTH(8)) i_crcc_top (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    always #2.5 clk = ~clk;

    // Bitwise reference, MSB first, no reflection
    function automatic logic [31:0] crcRef(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRCC_POLY) : {r[30:0], 1'b0};
        end
        return r;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write with response check; waits bounded
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] expResp);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 400) begin
            failures++;
            results();
        end else begin
            check({30'h0, s_axi_bresp}, {30'h0, expResp});
        end
    endtask

    // Read with data and response check; waits bounded
    task automatic rd(input logic [3:0] a, input logic [31:0] expData, input logic [1:0] expResp);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 400) begin
            failures++;
            results();
        end else begin
            check(s_axi_rdata, expData);
            check({30'h0, s_axi_rresp}, {30'h0, expResp});
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask

    initial begin
        logic [31:0] crc;
        logic [31:0] w;
        clk = 1'b0;
        rst = 1'b1;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wdata = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        checked = 0;
        failures = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(CRCC_OFS_DATA, CRCC_SEED, CRCC_RESP_OKAY);
        rd(CRCC_OFS_SCRATCH, 32'h0, CRCC_RESP_OKAY);
        rd(CRCC_OFS_CTRL, 32'h0, CRCC_RESP_OKAY);
        $display("test reset values done");
        crc = crcRef(CRCC_SEED, 32'h12345678);
        wr(CRCC_OFS_DATA, 32'h12345678, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        $display("test single word done");
        for (int i = 1; i <= 48; i++) begin
            w = 32'h9e3779b9 * i;
            crc = crcRef(crc, w);
            wr(CRCC_OFS_DATA, w, 4'hf, CRCC_RESP_OKAY);
        end
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        crc = crcRef(crc, 32'h0);
        wr(CRCC_OFS_DATA, 32'h0, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        $display("test back to back words done");
        wr(CRCC_OFS_SCRATCH, 32'hdeadbea5, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_SCRATCH, 32'h000000a5, CRCC_RESP_OKAY);
        wr(CRCC_OFS_SCRATCH, 32'h0000003c, 4'he, CRCC_RESP_OKAY);
        rd(CRCC_OFS_SCRATCH, 32'h000000a5, CRCC_RESP_OKAY);
        crc = crcRef(crc, 32'hffffffff);
        wr(CRCC_OFS_DATA, 32'hffffffff, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        wr(CRCC_OFS_CTRL, 32'hfffffffe, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        $display("test scratch byte done");
        wr(CRCC_OFS_CTRL, 32'h00000001, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_DATA, CRCC_SEED, CRCC_RESP_OKAY);
        rd(CRCC_OFS_SCRATCH, 32'h000000a5, CRCC_RESP_OKAY);
        rd(CRCC_OFS_CTRL, 32'h0, CRCC_RESP_OKAY);
        crc = crcRef(CRCC_SEED, 32'h80000001);
        wr(CRCC_OFS_DATA, 32'h80000001, 4'hf, CRCC_RESP_OKAY);
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        $display("test re-seed done");
        wr(4'hc, 32'h5a5a5a5a, 4'hf, CRCC_RESP_SLVERR);
        rd(4'hc, 32'h0, CRCC_RESP_SLVERR);
        wr(CRCC_OFS_DATA, 32'h5a5a5a5a, 4'h3, CRCC_RESP_SLVERR);
        rd(CRCC_OFS_DATA, crc, CRCC_RESP_OKAY);
        $display("test refusals done");
        doReset();
        rd(CRCC_OFS_DATA, CRCC_SEED, CRCC_RESP_OKAY);
        rd(CRCC_OFS_SCRATCH, 32'h0, CRCC_RESP_OKAY);
        $display("test second reset done");
        results();
    end
endmodule

`default_nettype wire
